// ### rtl/ibcm_crc8.sv
// One-byte CRC-8 step, MSB first, for packet build and check.
// Assumes a purely combinational use by the engine in the same clock.
`timescale 1ns/10ps

module ibcm_crc8 #(
    parameter logic [7:0] POLY = 8'h07
) (
    // Running value and next byte
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data_in,
    // Updated value
    output logic [7:0] crc_out
);

    // ------------------------------------------------------------------
    // Bit-serial division unrolled over one byte
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            // Shift and fold in the polynomial on a carry
            c = c[7] ? ({c[6:0], 1'b0} ^ POLY) : {c[6:0], 1'b0};
        end
        crc_out = c;
    end

endmodule // ibcm_crc8

// ### rtl/ibcm_host.sv
// Host-side in-band control message engine for a half-rate serial PHY.
// Assumes byte-wide symbol ports to an 8b/10b serializer and deserializer
// that run on core_clk; software reaches it over classic Wishbone.
//
// How it works
// - Separate transmit and receive serial lanes
// - Host provides PHY reference clock
// - Drive power-good reset; honour clock request
// - Carry frames only, no expansion-bus packets
// - Send idle symbols; receiver syncs per gigabit
// - Port runs half rate from preloaded config
// - Start symbol, trailing CRC excluding start
// - Request control byte: cmd, rw, register
// - Write data MSB first; zeros for read
// - Last byte: PHY address, top bits zero
// - Acknowledge status with control byte C0
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps

module ibcm_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Transmit lane symbol port
    output logic [7:0] tx_data,
    output logic tx_is_k,
    output logic tx_valid,
    input wire logic tx_ready,
    // Receive lane symbol port
    input wire logic [7:0] rx_data,
    input wire logic rx_is_k,
    input wire logic rx_valid,
    input wire logic rx_sync,
    // PHY side pins
    output logic power_clock_good_reset_n,
    input wire logic refclk_request_n,
    output logic refclk_enable,
    output logic half_rate_serial_mode
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wb_ack; // Bus answer
        logic [31:0] wb_dat; // Bus read data
        logic [2:0] ctrl; // Control bits
        logic [4:0] cmd_reg; // Register number
        logic [4:0] cmd_phy; // PHY address
        logic cmd_wr; // Write access
        logic [15:0] cmd_data; // Write value
        logic mdio_busy; // Awaiting response
        logic mdio_pend; // Request not yet sent
        logic mdio_done; // Response taken
        logic [15:0] mdio_rdata; // Returned data
        logic [15:0] status; // Last status bytes
        logic stat_new; // Status arrived
        logic crc_err; // Bad packet seen
        logic ack_pend; // Acknowledge owed
        ibcm_pkg::ibcm_tx_state_t tx_state; // Transmit sequencer
        logic [2:0] tx_idx; // Byte in packet
        logic [7:0] tx_crc; // Running transmit CRC
        logic tx_kind; // 1 register access, 0 acknowledge
        logic [7:0] tx_data; // Byte on the lane
        logic tx_is_k; // Control symbol flag
        logic idle_ph; // Comma just sent
        ibcm_pkg::ibcm_rx_state_t rx_state; // Receive parser
        logic [2:0] rx_idx; // Byte in packet
        logic [7:0] rx_crc; // Running receive CRC
        logic [31:0] rx_buf; // Control and three data bytes
        logic [1:0] req_sync; // Clock request synchroniser
        logic refclk_on; // Reference clock enable
    } ibcm_state_t;

    ibcm_state_t st; // Registered state
    ibcm_state_t next_st; // Next state
    logic [7:0] tx_body_byte; // Next packet byte
    logic [7:0] tx_crc_step; // CRC after that byte
    logic [7:0] rx_crc_step; // CRC after received byte
    logic [7:0] rx_ctl; // Received control byte
    logic bus_req; // New bus cycle
    logic bus_wr; // Full-word write
    logic rx_done; // Good packet complete
    logic rx_is_status; // Complete packet is status

    // ------------------------------------------------------------------
    // Outgoing packet bytes
    // ------------------------------------------------------------------
    // Byte at a given index of the packet of the given kind
    function automatic logic [7:0] pkt_byte(input logic kind,
                                            input logic [2:0] idx,
                                            input ibcm_state_t s);
        logic [7:0] b;
        b = 8'h00;
        if (!kind) begin
            if (idx == 3'h1) begin
                b = ibcm_pkg::CTL_STATUS_ACK;
            end
        end else begin
            unique case (idx)
                3'h1: b = {2'b00, s.cmd_wr, s.cmd_reg};
                3'h2: b = s.cmd_wr ? s.cmd_data[15:8] : 8'h00;
                3'h3: b = s.cmd_wr ? s.cmd_data[7:0] : 8'h00;
                3'h4: b = {3'b000, s.cmd_phy};
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction

    assign tx_body_byte = pkt_byte(st.tx_kind, st.tx_idx + 3'h1, st);

    // Same generator for build and check
    ibcm_crc8 #(.POLY(ibcm_pkg::CRC_POLY)) u_tx_crc (
        .crc_in(st.tx_crc),
        .data_in(tx_body_byte),
        .crc_out(tx_crc_step)
    );

    ibcm_crc8 #(.POLY(ibcm_pkg::CRC_POLY)) u_rx_crc (
        .crc_in(st.rx_crc),
        .data_in(rx_data),
        .crc_out(rx_crc_step)
    );

    // ------------------------------------------------------------------
    // Decodes shared by logic and checks
    // ------------------------------------------------------------------
    assign bus_req = wb_cyc_i && wb_stb_i && !st.wb_ack;
    assign bus_wr = bus_req && wb_we_i && (wb_sel_i == 4'hf);
    assign rx_ctl = st.rx_buf[31:24];
    // Good packet ends when the CRC byte matches the running value
    assign rx_done = rx_valid && !rx_is_k && (st.rx_state == ibcm_pkg::RX_BODY)
        && (st.rx_idx == ibcm_pkg::IDX_RX_CRC) && (rx_data == st.rx_crc);
    assign rx_is_status = rx_ctl[ibcm_pkg::CTL_STATUS_BIT]
        && !rx_ctl[ibcm_pkg::CTL_ACK_BIT];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Wishbone: answer one cycle after the request, drop next cycle
        next_st.wb_ack = bus_req;
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                ibcm_pkg::ADR_CTRL: next_st.wb_dat = {29'h0, st.ctrl};
                ibcm_pkg::ADR_CMD: next_st.wb_dat = {st.cmd_data, 5'h0,
                    st.cmd_wr, st.cmd_phy, st.cmd_reg};
                ibcm_pkg::ADR_MDIO: next_st.wb_dat = {14'h0, st.mdio_done,
                    st.mdio_busy, st.mdio_rdata};
                ibcm_pkg::ADR_STAT: next_st.wb_dat = {14'h0, st.crc_err,
                    st.stat_new, st.status};
                ibcm_pkg::ADR_LINK: next_st.wb_dat = {30'h0, rx_sync,
                    st.refclk_on};
                default: next_st.wb_dat = 32'h0; // Unmapped reads zero
            endcase
        end
        // Register writes; clears come before hardware sets
        if (bus_wr) begin
            unique case (wb_adr_i)
                ibcm_pkg::ADR_CTRL: next_st.ctrl = wb_dat_i[2:0];
                ibcm_pkg::ADR_CMD: begin
                    // New request only when none is outstanding
                    if (!st.mdio_busy) begin
                        next_st.cmd_reg = wb_dat_i[4:0];
                        next_st.cmd_phy = wb_dat_i[9:5];
                        next_st.cmd_wr = wb_dat_i[10];
                        next_st.cmd_data = wb_dat_i[31:16];
                        next_st.mdio_busy = 1'b1;
                        next_st.mdio_pend = 1'b1;
                        next_st.mdio_done = 1'b0;
                    end
                end
                ibcm_pkg::ADR_STAT: begin
                    if (wb_dat_i[ibcm_pkg::STAT_NEW_BIT]) begin
                        next_st.stat_new = 1'b0;
                    end
                    if (wb_dat_i[ibcm_pkg::STAT_CRCERR_BIT]) begin
                        next_st.crc_err = 1'b0;
                    end
                end
                default: ; // Other writes ignored
            endcase
        end
        // Transmit lane: advance when the serializer takes a symbol
        if (tx_ready) begin
            if (st.tx_state == ibcm_pkg::TX_IDLE) begin
                if (st.idle_ph) begin
                    // Second half of the idle ordered set
                    next_st.tx_data = ibcm_pkg::D16_2;
                    next_st.tx_is_k = 1'b0;
                    next_st.idle_ph = 1'b0;
                end else if (st.ack_pend || st.mdio_pend) begin
                    // Control packets slot between idles only
                    next_st.tx_state = ibcm_pkg::TX_PKT;
                    next_st.tx_idx = 3'h0;
                    next_st.tx_crc = ibcm_pkg::CRC_INIT;
                    next_st.tx_kind = !st.ack_pend;
                    next_st.tx_data = ibcm_pkg::K28_1;
                    next_st.tx_is_k = 1'b1;
                    if (st.ack_pend) begin
                        next_st.ack_pend = 1'b0;
                    end else begin
                        next_st.mdio_pend = 1'b0;
                    end
                end else begin
                    next_st.tx_data = ibcm_pkg::K28_5;
                    next_st.tx_is_k = 1'b1;
                    next_st.idle_ph = 1'b1;
                end
            end else if (st.tx_idx == ibcm_pkg::IDX_CRC) begin
                // Packet done, resume idles
                next_st.tx_state = ibcm_pkg::TX_IDLE;
                next_st.tx_data = ibcm_pkg::K28_5;
                next_st.tx_is_k = 1'b1;
                next_st.idle_ph = 1'b1;
            end else if (st.tx_idx == 3'h4) begin
                // Trailing CRC covers bytes after the start
                next_st.tx_idx = ibcm_pkg::IDX_CRC;
                next_st.tx_data = st.tx_crc;
                next_st.tx_is_k = 1'b0;
            end else begin
                next_st.tx_idx = st.tx_idx + 3'h1;
                next_st.tx_data = tx_body_byte;
                next_st.tx_is_k = 1'b0;
                next_st.tx_crc = tx_crc_step;
            end
        end
        // Receive lane parser
        if (rx_valid) begin
            if (rx_is_k) begin
                // Start symbol opens a packet; any other K aborts one
                if (rx_data == ibcm_pkg::K28_1) begin
                    next_st.rx_state = ibcm_pkg::RX_BODY;
                    next_st.rx_idx = 3'h0;
                    next_st.rx_crc = ibcm_pkg::CRC_INIT;
                end else begin
                    next_st.rx_state = ibcm_pkg::RX_HUNT;
                end
            end else if (st.rx_state == ibcm_pkg::RX_BODY) begin
                if (st.rx_idx == ibcm_pkg::IDX_RX_CRC) begin
                    next_st.rx_state = ibcm_pkg::RX_HUNT;
                    if (rx_data != st.rx_crc) begin
                        next_st.crc_err = 1'b1; // Dropped packet
                    end
                end else begin
                    next_st.rx_buf = {st.rx_buf[23:0], rx_data};
                    next_st.rx_crc = rx_crc_step;
                    next_st.rx_idx = st.rx_idx + 3'h1;
                end
            end
        end
        // Act on a good packet
        if (rx_done) begin
            if (rx_is_status) begin
                next_st.status = st.rx_buf[23:8];
                next_st.stat_new = 1'b1;
                if (st.ctrl[ibcm_pkg::CTRL_AUTO_BIT]) begin
                    next_st.ack_pend = 1'b1;
                end
            end else if (!rx_ctl[ibcm_pkg::CTL_STATUS_BIT]
                && rx_ctl[ibcm_pkg::CTL_ACK_BIT] && st.mdio_busy
                && !st.mdio_pend && (rx_ctl[4:0] == st.cmd_reg)) begin
                // Response matching the outstanding request
                next_st.mdio_rdata = st.rx_buf[23:8];
                next_st.mdio_busy = 1'b0;
                next_st.mdio_done = 1'b1;
            end
        end
        // Clock request pin, two flops before use
        next_st.req_sync = {st.req_sync[0], refclk_request_n};
        next_st.refclk_on = !st.req_sync[1];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= '0;
            st.ctrl <= ibcm_pkg::CTRL_RESET;
            st.tx_data <= ibcm_pkg::K28_5;
            st.tx_is_k <= 1'b1;
            st.idle_ph <= 1'b1;
            st.req_sync <= 2'b11;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o = st.wb_ack;
    assign wb_dat_o = st.wb_dat;
    assign tx_data = st.tx_data;
    assign tx_is_k = st.tx_is_k;
    assign tx_valid = 1'b1;
    assign power_clock_good_reset_n = st.ctrl[ibcm_pkg::CTRL_PWR_BIT];
    assign refclk_enable = st.refclk_on;
    assign half_rate_serial_mode = st.ctrl[ibcm_pkg::CTRL_HALF_BIT];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reset_holds_phy: assert property (@(posedge core_clk)
        reset |=> !power_clock_good_reset_n)
        else $error("PHY reset not held after host reset");

    a_idle_pair_order: assert property (@(posedge core_clk)
        disable iff (reset)
        (tx_ready && st.tx_state == ibcm_pkg::TX_IDLE && st.idle_ph)
        |=> (tx_data == ibcm_pkg::D16_2) && !tx_is_k)
        else $error("Comma not followed by idle data symbol");

    a_pkt_start_sym: assert property (@(posedge core_clk)
        disable iff (reset)
        $rose(st.tx_state == ibcm_pkg::TX_PKT)
        |-> (tx_data == ibcm_pkg::K28_1) && tx_is_k && st.tx_idx == 3'h0)
        else $error("Packet did not open with start symbol");

    a_crc_tail_byte: assert property (@(posedge core_clk)
        disable iff (reset)
        (tx_ready && st.tx_state == ibcm_pkg::TX_PKT && st.tx_idx == 3'h4)
        |=> tx_data == $past(st.tx_crc) && !tx_is_k)
        else $error("Trailing byte is not the running CRC");

    a_req_ctl_byte: assert property (@(posedge core_clk)
        disable iff (reset)
        (st.tx_state == ibcm_pkg::TX_PKT && st.tx_kind && st.tx_idx == 3'h1)
        |-> tx_data == {2'b00, st.cmd_wr, st.cmd_reg})
        else $error("Request control byte malformed");

    a_read_data_zero: assert property (@(posedge core_clk)
        disable iff (reset)
        (st.tx_state == ibcm_pkg::TX_PKT && st.tx_kind && !st.cmd_wr
        && (st.tx_idx == 3'h2 || st.tx_idx == 3'h3)) |-> tx_data == 8'h00)
        else $error("Read request carries nonzero data");

    a_phy_addr_byte: assert property (@(posedge core_clk)
        disable iff (reset)
        (st.tx_state == ibcm_pkg::TX_PKT && st.tx_kind && st.tx_idx == 3'h4)
        |-> tx_data == {3'b000, st.cmd_phy})
        else $error("PHY address byte malformed");

    a_status_ack_owed: assert property (@(posedge core_clk)
        disable iff (reset)
        (rx_done && rx_is_status && st.ctrl[ibcm_pkg::CTRL_AUTO_BIT])
        |=> st.ack_pend || st.tx_state == ibcm_pkg::TX_PKT)
        else $error("Status packet left unacknowledged");

    a_ack_ctl_byte: assert property (@(posedge core_clk)
        disable iff (reset)
        (st.tx_state == ibcm_pkg::TX_PKT && !st.tx_kind && st.tx_idx == 3'h1)
        |-> tx_data == ibcm_pkg::CTL_STATUS_ACK)
        else $error("Acknowledge control byte wrong");

    a_bus_ack_pulse: assert property (@(posedge core_clk)
        disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus answer held over two cycles");

endmodule // ibcm_host

// ### rtl/ibcm_pkg.sv
// Constants and types for the host-side in-band control message engine.
// Assumes a byte-wide 8b/10b symbol port on both lanes, in core_clk domain.

package ibcm_pkg;

    // ------------------------------------------------------------------
    // Symbols and CRC-8 generator
    // ------------------------------------------------------------------
    localparam logic [7:0] K28_1 = 8'h3c; // Packet start symbol (K flag set)
    localparam logic [7:0] K28_5 = 8'hbc; // Idle comma (K flag set)
    localparam logic [7:0] D16_2 = 8'h50; // Idle data half
    localparam logic [7:0] CRC_POLY = 8'h07; // Shared generator polynomial
    localparam logic [7:0] CRC_INIT = 8'h00; // Shared start value

    // ------------------------------------------------------------------
    // Packet layout
    // ------------------------------------------------------------------
    localparam int CTL_STATUS_BIT = 7; // Status class when set
    localparam int CTL_ACK_BIT = 6; // Acknowledge / response when set
    localparam int CTL_WRITE_BIT = 5; // Write access when set
    localparam logic [7:0] CTL_STATUS_ACK = 8'hc0; // Status acknowledge
    localparam logic [2:0] IDX_CRC = 3'h5; // Last index of an outgoing packet
    localparam logic [2:0] IDX_RX_CRC = 3'h4; // CRC index after the start

    // ------------------------------------------------------------------
    // Register map (byte addresses) and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00; // Control
    localparam logic [7:0] ADR_CMD = 8'h04; // Register access order
    localparam logic [7:0] ADR_MDIO = 8'h08; // Register access result
    localparam logic [7:0] ADR_STAT = 8'h0c; // Last PHY status
    localparam logic [7:0] ADR_LINK = 8'h10; // Link pins
    localparam int CTRL_PWR_BIT = 0; // Power/clock good to the PHY
    localparam int CTRL_HALF_BIT = 1; // Half-rate lane mode
    localparam int CTRL_AUTO_BIT = 2; // Acknowledge status automatically
    localparam logic [2:0] CTRL_RESET = 3'h6; // Reset held, half rate, auto
    localparam int STAT_NEW_BIT = 16; // New status arrived (write 1 clears)
    localparam int STAT_CRCERR_BIT = 17; // Bad CRC seen (write 1 clears)
    localparam int MDIO_BUSY_BIT = 16; // Request outstanding
    localparam int MDIO_DONE_BIT = 17; // Response arrived

    // ------------------------------------------------------------------
    // State machine codes
    // ------------------------------------------------------------------
    typedef enum logic {TX_IDLE = 1'b0, TX_PKT = 1'b1} ibcm_tx_state_t;
    typedef enum logic {RX_HUNT = 1'b0, RX_BODY = 1'b1} ibcm_rx_state_t;

endpackage

// ### tb/ibcm_host_tb.sv
// Self-checking bench for the host in-band control message engine.
// Assumes the PHY model above sits on both symbol lanes.
`timescale 1ns/10ps

module ibcm_host_tb;
    logic core_clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, tx_data, rx_data;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
    logic wb_ack_o, tx_is_k, tx_valid, rx_is_k, rx_valid, pcg_n, refclk_enable, half_rate_serial_mode;
    logic tx_ready = 1'b1, rx_sync = 1'b0, refclk_request_n = 1'b1;
    int failures = 0, n_checks = 0, a0, n;

    always #50 core_clk = ~core_clk;

    ibcm_host i_ibcm_host (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_data(tx_data),
        .tx_is_k(tx_is_k), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_is_k(rx_is_k), .rx_valid(rx_valid), .rx_sync(rx_sync),
        .power_clock_good_reset_n(pcg_n), .refclk_request_n(refclk_request_n),
        .refclk_enable(refclk_enable), .half_rate_serial_mode(half_rate_serial_mode));
    ibcm_phy_model i_ibcm_phy_model (.clk(core_clk), .reset(reset), .tx_data(tx_data),
        .tx_is_k(tx_is_k), .rx_data(rx_data), .rx_is_k(rx_is_k), .rx_valid(rx_valid));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            failures++;
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] v, output logic [31:0] q);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, v};
        // Only the watchdog ends a wait for the answer
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    // Register access through the PHY; read carries junk data to be zeroed
    task automatic mdio(input logic we, input logic [4:0] r, p, input logic [15:0] v);
        logic [31:0] q;
        wb(1'b1, ibcm_pkg::ADR_CMD, {v, 5'h0, we, p, r}, q);
        q = 32'h0;
        for (int k = 0; k < 100 && q[17] !== 1'b1; k++) wb(1'b0, ibcm_pkg::ADR_MDIO, 0, q);
        chk(i_ibcm_phy_model.pk[0], {2'b00, we, r});
        chk(i_ibcm_phy_model.pk[3], {3'h0, p});
        if (we) chk(i_ibcm_phy_model.mem[r], v);
        else begin chk({i_ibcm_phy_model.pk[1], i_ibcm_phy_model.pk[2]}, 0); chk(q[16:0], v); end
    endtask

    // Poll status until the new bit or the CRC error bit rises
    task automatic stat_wait(output logic [31:0] q);
        q = 32'h0;
        for (int k = 0; k < 100 && q[16] !== 1'b1 && q[17] !== 1'b1; k++) wb(1'b0, ibcm_pkg::ADR_STAT, 0, q);
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        wb(1'b0, ibcm_pkg::ADR_CTRL, 0, d);
        chk(d, {29'h0, ibcm_pkg::CTRL_RESET});
        chk({pcg_n, half_rate_serial_mode, tx_valid}, 3'b011);
        // Partial-lane write is refused, control keeps its reset value
        wb_sel_i <= 4'h3;
        wb(1'b1, ibcm_pkg::ADR_CTRL, 32'h0, d);
        wb_sel_i <= 4'hf;
        wb(1'b0, ibcm_pkg::ADR_CTRL, 0, d);
        chk(d, {29'h0, ibcm_pkg::CTRL_RESET});
        wb(1'b0, 8'h20, 0, d);
        chk(d, 0);
        refclk_request_n <= 1'b0;
        rx_sync <= 1'b1;
        wb(1'b1, ibcm_pkg::ADR_CTRL, 32'h7, d);
        wb(1'b0, ibcm_pkg::ADR_LINK, 0, d);
        chk({pcg_n, refclk_enable, d[29:0]}, 32'hc000_0003);
        mdio(1'b1, 5'h1f, 5'h1f, 16'ha5c3);
        mdio(1'b0, 5'h1f, 5'h1f, 16'ha5c3);
        mdio(1'b1, 5'h00, 5'h01, 16'h0001);
        mdio(1'b0, 5'h00, 5'h01, 16'h0001);
        for (int s = 0; s < 3; s++) begin
            a0 = i_ibcm_phy_model.n_ack;
            i_ibcm_phy_model.send_status(8'h27, 8'hac | s[7:0], 1'b0);
            stat_wait(d);
            chk(d[17:0], {2'b01, 8'h27, 8'hac | s[7:0]});
            for (n = 0; n < 200 && i_ibcm_phy_model.n_ack == a0; n++) @(posedge core_clk);
            chk(i_ibcm_phy_model.n_ack, a0 + 1);
            wb(1'b1, ibcm_pkg::ADR_STAT, 32'h0001_0000, d);
        end
        i_ibcm_phy_model.send_status(8'h01, 8'h02, 1'b1);
        stat_wait(d);
        chk(d[17:0], {2'b10, 8'h27, 8'hae});
        wb(1'b1, ibcm_pkg::ADR_CTRL, 32'h1, d);
        chk(half_rate_serial_mode, 1'b0);
        a0 = i_ibcm_phy_model.n_stat + 1;
        i_ibcm_phy_model.send_status(8'h04, 8'h88, 1'b0);
        for (n = 0; n < 400 && i_ibcm_phy_model.n_stat <= a0; n++) @(posedge core_clk);
        chk(i_ibcm_phy_model.n_stat, a0 + 1);
        close_out();
    end

    // Watchdog
    initial begin
        #(100 * 20000);
        failures++;
        close_out();
    end
endmodule // ibcm_host_tb

// ### tb/ibcm_phy_model.sv
// Behavioural PHY at the far end of the host's symbol lanes.
// Assumes tx_ready is held high, so one host symbol is taken per clock.
`timescale 1ns/10ps

module ibcm_phy_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host transmit lane, seen here
    input wire logic [7:0] tx_data,
    input wire logic tx_is_k,
    // Host receive lane, driven here
    output logic [7:0] rx_data,
    output logic rx_is_k,
    output logic rx_valid
);
    localparam int RESEND = 300; // Wait for an acknowledge, in cycles
    logic [8:0] q[$]; // Symbols waiting to go out
    logic [7:0] pk[5]; // Last host packet after the start symbol
    logic [15:0] mem[32]; // Register file
    logic [7:0] sb1, sb2; // Status kept for a resend
    logic pend = 1'b0; // Status awaits acknowledge
    int idx = 0, n_ack = 0, n_stat = 0, tmo = 0;
    initial rx_data = 8'h5a;

    // One CRC-8 step, MSB first, shared seed and polynomial
    function automatic logic [7:0] crc(input logic [7:0] c,
                                       input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? (x << 1) ^ ibcm_pkg::CRC_POLY : x << 1;
        end
        return x;
    endfunction

    // Queue a whole packet; bad flips the CRC
    task automatic push(input logic [7:0] c, b1, b2, input logic bad);
        logic [7:0] r;
        r = crc(crc(crc(crc(ibcm_pkg::CRC_INIT, c), b1), b2), 8'h00);
        q.push_back({1'b1, ibcm_pkg::K28_1});
        q.push_back({1'b0, c});
        q.push_back({1'b0, b1});
        q.push_back({1'b0, b2});
        q.push_back(9'h000);
        q.push_back({1'b0, r ^ {7'h0, bad}});
    endtask

    // Originate a status packet; a good one is resent until acknowledged
    task automatic send_status(input logic [7:0] b1, b2, input logic bad);
        sb1 = b1;
        sb2 = b2;
        pend = !bad;
        tmo = 0;
        n_stat++;
        push(8'h80, b1, b2, bad);
    endtask

    // Send queued symbols, parse host packets, resend on timeout
    always @(posedge clk) begin
        if (!reset && q.size() > 0) begin
            {rx_valid, rx_is_k, rx_data} <= {1'b1, q.pop_front()};
        end else begin
            // Idle lane toggles, no stale value
            {rx_valid, rx_is_k, rx_data} <= {2'b00, ~rx_data};
        end
        if (reset) begin
            idx = 0;
            pend = 1'b0;
        end else begin
            if (tx_is_k) begin
                idx = (tx_data == ibcm_pkg::K28_1) ? 1 : 0;
            end else if (idx > 0) begin
                pk[idx-1] = tx_data;
                idx = (idx == 5) ? 0 : idx + 1;
                // Bad CRC is dropped, answer follows the access
                if (idx == 0 && crc(crc(crc(crc(ibcm_pkg::CRC_INIT, pk[0]),
                        pk[1]), pk[2]), pk[3]) == pk[4]) begin
                    if (pk[0] == ibcm_pkg::CTL_STATUS_ACK) begin
                        pend = 1'b0;
                        n_ack++;
                    end else if (pk[0][7:6] == 2'b00) begin
                        if (pk[0][5]) mem[pk[0][4:0]] = {pk[1], pk[2]};
                        push({2'b01, pk[0][5:0]}, mem[pk[0][4:0]][15:8],
                            mem[pk[0][4:0]][7:0], 1'b0);
                    end
                end
            end
            if (pend && ++tmo == RESEND) begin
                tmo = 0;
                n_stat++;
                // Single interface here: the resend stays on this lane
                push(8'h80, sb1, sb2, 1'b0);
            end
        end
    end
endmodule // ibcm_phy_model
